/* File: sram_port_pkg.sv */
// shared constants and command type for the burst sram port
package sram_port_pkg;
  localparam int DATA_W_DEF = 18; // word width per beat: 8, 9 or 18
  localparam int ADDR_W_DEF = 20; // burst address width
  localparam int BEATS = 2; // words per burst
  localparam int SEL_W = 2; // lane select pins per beat
  localparam int SYNC_STAGES = 2; // flip-flops ahead of any logic
  localparam int CLK_PERIOD_NS = 100; // ref_clk period
  localparam logic SEL_IDLE = 1'b1; // select pin value that blocks a lane
  localparam logic LD_IDLE = 1'b1; // strobe level of a deselected port
  localparam logic OE_RESET = 1'b0; // outputs float after reset
  localparam logic RW_READ = 1'b1; // read_write_select level for a read
  localparam int WIDTH_X9 = 9; // single lane width
  localparam int BEAT0_LSB = 0; // word layout: beat 0 in the low half

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_WRITE,
    OP_READ
  } op_t;
endpackage

/* File: array_if.sv */
// array access bundle between the port control and the burst array
`timescale 1ns/1ps
interface array_if #(
  parameter int ADDR_W = 20,
  parameter int WORD_W = 36
) (
  input wire logic clk // shared clock
);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [WORD_W-1:0] wr_data;
  logic [WORD_W-1:0] wr_mask;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output wr_mask,
    output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input wr_mask,
    input rd_addr, output rd_data);
endinterface

/* File: burst_array.sv */
// burst memory array with bit masked write and registered read
`timescale 1ns/1ps
module burst_array
  import sram_port_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int WORD_W = 36
) (
  input wire logic clk, // array clock
  input wire logic rst_n_sync, // synchronised reset, active low
  array_if.mem bus // write and read ports
);
  logic [WORD_W-1:0] mem_q [0:(1<<ADDR_W)-1];
  logic [WORD_W-1:0] rd_q;

  // masked write keeps the bits whose lane was blocked
  always_ff @(posedge clk) begin
    if (bus.wr_en) begin
      mem_q[bus.wr_addr] <= (mem_q[bus.wr_addr] & ~bus.wr_mask) | (bus.wr_data & bus.wr_mask);
    end
  end

  // read data come out of a register
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rd_q <= '0;
    end else begin
      rd_q <= mem_q[bus.rd_addr];
    end
  end

  assign bus.rd_data = rd_q;
endmodule

/* File: lane_decode.sv */
// turns one beat of active low lane selects into a bit write mask
`timescale 1ns/1ps
module lane_decode
  import sram_port_pkg::*;
#(
  parameter int DATA_W = 18
) (
  input wire logic [SEL_W-1:0] sel_n, // lane selects, low writes the lane
  output logic [DATA_W-1:0] mask // one bit per data bit, high writes
);
  localparam int HALF = DATA_W / 2;

  generate
    if (DATA_W == WIDTH_X9) begin : g_single
      // one select covers all nine bits; high blocks the whole beat
      assign mask = {DATA_W{~sel_n[0]}};
    end else begin : g_dual
      // low half follows select 0, high half select 1
      assign mask = {{HALF{~sel_n[1]}}, {HALF{~sel_n[0]}}};
    end
  endgenerate
endmodule

/* File: ddr_sio_sram_port.sv */
// command, write and read pipeline of the two word burst sram port
`timescale 1ns/1ps
module ddr_sio_sram_port
  import sram_port_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic ref_clk, // input clock, true edge domain
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic clocks_stopped, // high while the input clocks are stopped
  input wire logic load_strobe_n, // command strobe, active low
  input wire logic read_write_select, // high read, low write
  input wire logic [ADDR_W-1:0] address, // burst address
  input wire logic [DATA_W-1:0] write_data_k, // beat on the true input edge
  input wire logic [DATA_W-1:0] write_data_kn, // beat on the complementary edge
  input wire logic [SEL_W-1:0] byte_write_select_n_k, // lane selects, true edge beat
  input wire logic [SEL_W-1:0] byte_write_select_n_kn, // lane selects, complementary beat
  output logic [DATA_W-1:0] read_data_cn, // word A+0, complementary output edge
  output logic read_data_cn_oe, // high while read_data_cn is driven
  output logic [DATA_W-1:0] read_data_c, // word A+1, true output edge
  output logic read_data_c_oe // high while read_data_c is driven
);
  localparam int WORD_W = BEATS * DATA_W;
  localparam int IN_W = 3 + ADDR_W + 2 * DATA_W + 2 * SEL_W;
  localparam logic [IN_W-1:0] IN_RESET = {1'b0, LD_IDLE, 1'b0, {ADDR_W{1'b0}},
    {(2 * DATA_W){1'b0}}, {(2 * SEL_W){SEL_IDLE}}};

  logic [1:0] rst_sync_q;
  logic rst_n_sync;
  logic [IN_W-1:0] in_s1_q;
  logic [IN_W-1:0] in_s2_q;

  // synchronised pin views
  logic s_stopped;
  logic s_ld_n;
  logic s_rw;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_wd_k;
  logic [DATA_W-1:0] s_wd_kn;
  logic [SEL_W-1:0] s_sel_k;
  logic [SEL_W-1:0] s_sel_kn;

  // pipeline state
  op_t op_q;
  op_t op_d;
  logic [ADDR_W-1:0] addr_q;
  logic rd_data_v_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic pend_v_q;
  logic [ADDR_W-1:0] pend_addr_q;
  logic [WORD_W-1:0] pend_data_q;
  logic [WORD_W-1:0] pend_mask_q;
  logic [DATA_W-1:0] word1_q;
  logic word1_v_q;
  logic [DATA_W-1:0] q_cn_q;
  logic q_cn_oe_q;
  logic [DATA_W-1:0] q_c_q;
  logic q_c_oe_q;

  logic running;
  logic take_write_data;
  logic [SEL_W-1:0] beat_sel [BEATS];
  logic [DATA_W-1:0] beat_mask [BEATS];
  logic [WORD_W-1:0] new_mask;
  logic [WORD_W-1:0] new_data;
  logic pend_hit;
  logic [WORD_W-1:0] read_word;

  array_if #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) arr (.clk(ref_clk));

  // reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_q[1];

  // every pin passes two flip-flops; only the second stage is read
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      in_s1_q <= IN_RESET;
      in_s2_q <= IN_RESET;
    end else begin
      in_s1_q <= {clocks_stopped, load_strobe_n, read_write_select, address,
        write_data_k, write_data_kn, byte_write_select_n_k, byte_write_select_n_kn};
      in_s2_q <= in_s1_q;
    end
  end
  assign {s_stopped, s_ld_n, s_rw, s_addr, s_wd_k, s_wd_kn, s_sel_k, s_sel_kn} = in_s2_q;

  // standby freezes the pipeline behind the pin synchroniser and the outputs; the synchroniser keeps sampling
  assign running = ~s_stopped;

  // command decode; strobe high is a no operation whatever the select
  always_comb begin
    op_d = OP_IDLE;
    if (running && !s_ld_n) begin
      op_d = (s_rw == RW_READ) ? OP_READ : OP_WRITE;
    end
  end

  // command register and latched burst address
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      op_q <= OP_IDLE;
      addr_q <= '0;
    end else if (running) begin
      op_q <= op_d;
      if (op_d != OP_IDLE) begin
        addr_q <= s_addr;
      end
    end
  end

  // data beats of a write arrive in the cycle after its command
  assign take_write_data = running && (op_q == OP_WRITE);
  assign beat_sel[0] = s_sel_k;
  assign beat_sel[1] = s_sel_kn;

  // each beat decodes its own lane selects
  generate
    for (genvar b = 0; b < BEATS; b++) begin : g_beat
      lane_decode #(.DATA_W(DATA_W)) u_lane (
        .sel_n(beat_sel[b]),
        .mask(beat_mask[b])
      );
    end
  endgenerate

  // word A+0 sits in the low half, A+1 in the high half
  assign new_mask = {beat_mask[1], beat_mask[BEAT0_LSB]};
  assign new_data = {s_wd_kn, s_wd_k};

  // posted write: the held write is committed when the next one arrives
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pend_v_q <= 1'b0;
      pend_addr_q <= '0;
      pend_data_q <= '0;
      pend_mask_q <= '0;
    end else if (take_write_data) begin
      pend_v_q <= 1'b1;
      pend_addr_q <= addr_q;
      pend_data_q <= new_data;
      pend_mask_q <= new_mask;
    end
  end

  // array ports: commit old posted write, read at the command address
  assign arr.wr_en = take_write_data && pend_v_q;
  assign arr.wr_addr = pend_addr_q;
  assign arr.wr_data = pend_data_q;
  assign arr.wr_mask = pend_mask_q;
  // standby re-reads the last address so the array output cannot drift
  assign arr.rd_addr = running ? s_addr : rd_addr_q;

  burst_array #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) u_array (
    .clk(ref_clk),
    .rst_n_sync(rst_n_sync),
    .bus(arr.mem)
  );

  // reads of the held address see the posted data merged in
  assign pend_hit = pend_v_q && (pend_addr_q == rd_addr_q);
  assign read_word = pend_hit ?
    ((arr.rd_data & ~pend_mask_q) | (pend_data_q & pend_mask_q)) : arr.rd_data;

  // read tracking: array data are ready one cycle after the command
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      rd_data_v_q <= 1'b0;
      rd_addr_q <= '0;
    end else if (running) begin
      rd_data_v_q <= (op_d == OP_READ);
      rd_addr_q <= s_addr;
    end
  end

  // output registers: A+0 first, A+1 one cycle behind it
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      q_cn_q <= '0;
      q_cn_oe_q <= OE_RESET;
      word1_q <= '0;
      word1_v_q <= 1'b0;
      q_c_q <= '0;
      q_c_oe_q <= OE_RESET;
    end else if (running) begin
      q_cn_oe_q <= rd_data_v_q;
      word1_v_q <= rd_data_v_q;
      q_c_oe_q <= word1_v_q;
      if (rd_data_v_q) begin
        q_cn_q <= read_word[DATA_W-1:0];
        word1_q <= read_word[WORD_W-1:DATA_W];
      end
      if (word1_v_q) begin
        q_c_q <= word1_q;
      end
    end
  end

  assign read_data_cn = q_cn_q;
  assign read_data_cn_oe = q_cn_oe_q;
  assign read_data_c = q_c_q;
  assign read_data_c_oe = q_c_oe_q;
endmodule

/* File: sram_port_props.sv */
// pin level checks of the burst sram port
`timescale 1ns/1ps
module sram_port_props
  import sram_port_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic ref_clk, // port clock
  input wire logic rst_n, // reset, active low
  input wire logic clocks_stopped, // standby
  input wire logic load_strobe_n, // command strobe
  input wire logic read_write_select, // high read
  input wire logic [DATA_W-1:0] read_data_cn, // word A+0
  input wire logic read_data_cn_oe, // A+0 driven
  input wire logic [DATA_W-1:0] read_data_c, // word A+1
  input wire logic read_data_c_oe // A+1 driven
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // command decode at the pins
  wire rd_go = !load_strobe_n && read_write_select == RW_READ && !clocks_stopped;
  wire no_rd = (load_strobe_n || read_write_select != RW_READ) && !clocks_stopped;
  sequence run4;
    !clocks_stopped [*4];
  endsequence
  read_first_a: assert property (rd_go ##1 run4 |-> read_data_cn_oe)
    else $error("first read word not driven");
  read_second_a: assert property (rd_go ##1 run4 |=> read_data_c_oe)
    else $error("second read word not driven");
  read_pulse_a: assert property (rd_go ##1 load_strobe_n ##0 run4 |=> !read_data_cn_oe)
    else $error("first word driven too long");
  nop_float_a: assert property (no_rd ##1 run4 |-> !read_data_cn_oe)
    else $error("output driven without read");
  beat_order_a: assert property ($rose(read_data_c_oe) |-> $past(read_data_cn_oe))
    else $error("second word before first");
  second_off_a: assert property ($fell(read_data_cn_oe) && !$past(clocks_stopped, 2)
    |=> !read_data_c_oe)
    else $error("second word not released");
  standby_hold_a: assert property (clocks_stopped [*4] |-> $stable(read_data_cn) &&
    $stable(read_data_c) && $stable(read_data_cn_oe) && $stable(read_data_c_oe))
    else $error("outputs moved in standby");
  reset_quiet_a: assert property ($rose(rst_n) |-> (!read_data_cn_oe && !read_data_c_oe) [*4])
    else $error("outputs driven after reset");
  // main scenarios reached
  cover property (rd_go);
  cover property (!load_strobe_n && !read_write_select);
  cover property (clocks_stopped [*4]);
endmodule

bind ddr_sio_sram_port sram_port_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) props (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .clocks_stopped(clocks_stopped),
  .load_strobe_n(load_strobe_n),
  .read_write_select(read_write_select),
  .read_data_cn(read_data_cn),
  .read_data_cn_oe(read_data_cn_oe),
  .read_data_c(read_data_c),
  .read_data_c_oe(read_data_c_oe)
);

/* File: host_model.sv */
// memory controller model issuing commands and write bursts
`timescale 1ns/1ps
module host_model
  import sram_port_pkg::*;
(
  input wire logic ref_clk, // port clock
  output logic load_strobe_n, // command strobe
  output logic read_write_select, // high read
  output logic [ADDR_W_DEF-1:0] address, // burst address
  output logic [DATA_W_DEF-1:0] write_data_k, // beat A+0
  output logic [DATA_W_DEF-1:0] write_data_kn, // beat A+1
  output logic [SEL_W-1:0] byte_write_select_n_k, // selects A+0
  output logic [SEL_W-1:0] byte_write_select_n_kn // selects A+1
);
  // idle pins at time zero
  initial begin
    load_strobe_n = LD_IDLE;
    read_write_select = RW_READ;
    address = '0;
    write_data_k = '0;
    write_data_kn = '1;
    byte_write_select_n_k = 2'h3;
    byte_write_select_n_kn = 2'h3;
  end
  // command cycle, released lines invert so stale values never match
  task automatic cmd(input logic rw, input logic [ADDR_W_DEF-1:0] a);
    @(posedge ref_clk);
    #1;
    load_strobe_n = 1'b0;
    read_write_select = rw;
    address = a;
    @(posedge ref_clk);
    #1;
    load_strobe_n = LD_IDLE;
    address = ~a;
  endtask
  task automatic rd(input logic [ADDR_W_DEF-1:0] a);
    cmd(RW_READ, a);
  endtask
  // data follows one cycle after the command, per beat selects
  task automatic wr(input logic [ADDR_W_DEF-1:0] a, input logic [17:0] d0, d1,
    input logic [1:0] s0, s1);
    cmd(1'b0, a);
    write_data_k = d0;
    write_data_kn = d1;
    byte_write_select_n_k = s0;
    byte_write_select_n_kn = s1;
    @(posedge ref_clk);
    #1;
    write_data_k = ~d0;
    write_data_kn = ~d1;
    byte_write_select_n_k = 2'h3;
    byte_write_select_n_kn = 2'h3;
  endtask
endmodule

/* File: test_ddr_sio_sram_port.sv */
// self checking bench for the burst sram port
`timescale 1ns/1ps
module test_ddr_sio_sram_port;
  import sram_port_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clocks_stopped = 1'b0;
  logic load_strobe_n;
  logic read_write_select;
  logic [ADDR_W_DEF-1:0] address;
  logic [DATA_W_DEF-1:0] write_data_k, write_data_kn, read_data_cn, read_data_c;
  logic [SEL_W-1:0] byte_write_select_n_k, byte_write_select_n_kn;
  logic read_data_cn_oe, read_data_c_oe;
  logic [17:0] w0, w1;
  logic [7:0] nib_cn, nib_c;
  logic nib_cn_oe, nib_c_oe;
  logic [8:0] one_cn, one_c;
  logic one_cn_oe, one_c_oe;
  int n_fail = 0;
  int n_tests = 0;
  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  ddr_sio_sram_port DUT (.*);
  host_model ctl (.*);
  // nibble wide port shares the host pins through their low bits
  ddr_sio_sram_port #(.DATA_W(8), .ADDR_W(ADDR_W_DEF)) dut_nib (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clocks_stopped(clocks_stopped),
    .load_strobe_n(load_strobe_n),
    .read_write_select(read_write_select),
    .address(address),
    .write_data_k(write_data_k[7:0]),
    .write_data_kn(write_data_kn[7:0]),
    .byte_write_select_n_k(byte_write_select_n_k),
    .byte_write_select_n_kn(byte_write_select_n_kn),
    .read_data_cn(nib_cn),
    .read_data_cn_oe(nib_cn_oe),
    .read_data_c(nib_c),
    .read_data_c_oe(nib_c_oe)
  );
  // single lane port, only select bit 0 matters
  ddr_sio_sram_port #(.DATA_W(9), .ADDR_W(ADDR_W_DEF)) dut_one (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clocks_stopped(clocks_stopped),
    .load_strobe_n(load_strobe_n),
    .read_write_select(read_write_select),
    .address(address),
    .write_data_k(write_data_k[8:0]),
    .write_data_kn(write_data_kn[8:0]),
    .byte_write_select_n_k(byte_write_select_n_k),
    .byte_write_select_n_kn(byte_write_select_n_kn),
    .read_data_cn(one_cn),
    .read_data_cn_oe(one_cn_oe),
    .read_data_c(one_c),
    .read_data_c_oe(one_c_oe)
  );
  task chk(input logic [17:0] g, input logic [17:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  // expected word after a masked beat
  function automatic logic [17:0] mrg(input logic [17:0] o, n, input logic [1:0] s);
    logic [17:0] m;
    m = {{9{~s[1]}}, {9{~s[0]}}};
    return (o & ~m) | (n & m);
  endfunction
  task rd_chk(input logic [19:0] a, input logic [17:0] e0, e1, n0, n1, u0, u1);
    ctl.rd(a);
    repeat (3) @(posedge ref_clk);
    #1;
    chk(read_data_cn, e0);
    chk(read_data_cn_oe, 1'b1);
    chk({nib_cn_oe, one_cn_oe}, 2'h3);
    chk(nib_cn, n0);
    chk(one_cn, u0);
    @(posedge ref_clk);
    #1;
    chk(read_data_c, e1);
    chk(nib_c, n1);
    chk(one_c, u1);
    chk({read_data_c_oe, read_data_cn_oe}, 2'h2);
    @(posedge ref_clk);
    #1;
    chk(read_data_c_oe, 1'b0);
  endtask
  task t_full;
    w0 = 18'h1_2345;
    w1 = 18'h2_abcd;
    ctl.wr(20'h0_0005, w0, w1, 2'h0, 2'h0);
    rd_chk(20'h0_0005, w0, w1, 18'h0_0045, 18'h0_00cd, 18'h0_0145, 18'h0_01cd);
  endtask
  task t_lanes;
    ctl.wr(20'h0_0005, 18'h3_ffff, 18'h0_0000, 2'h2, 2'h1);
    w0 = mrg(w0, 18'h3_ffff, 2'h2);
    w1 = mrg(w1, 18'h0_0000, 2'h1);
    rd_chk(20'h0_0005, w0, w1, 18'h0_004f, 18'h0_000d, 18'h0_01ff, 18'h0_01cd);
  endtask
  task t_none;
    ctl.wr(20'h0_0005, 18'h0_0000, 18'h3_ffff, 2'h3, 2'h3);
    rd_chk(20'h0_0005, w0, w1, 18'h0_004f, 18'h0_000d, 18'h0_01ff, 18'h0_01cd);
  endtask
  task t_addr;
    ctl.wr(20'h8_000a, 18'h0_1111, 18'h0_2222, 2'h0, 2'h0);
    rd_chk(20'h8_000a, 18'h0_1111, 18'h0_2222, 18'h0_0011, 18'h0_0022,
      18'h0_0111, 18'h0_0022);
    rd_chk(20'h0_0005, w0, w1, 18'h0_004f, 18'h0_000d, 18'h0_01ff, 18'h0_01cd);
  endtask
  // a read caught by standby holds its first word; a read issued while stopped never comes out
  task t_stby;
    ctl.rd(20'h0_0005);
    @(posedge ref_clk);
    #1;
    clocks_stopped = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk({read_data_c_oe, read_data_cn_oe}, 2'h1);
    chk(read_data_cn, w0);
    ctl.rd(20'h8_000a);
    repeat (4) @(posedge ref_clk);
    #1;
    chk({read_data_c_oe, read_data_cn_oe}, 2'h1);
    clocks_stopped = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(read_data_c, w1);
    chk({read_data_c_oe, read_data_cn_oe}, 2'h2);
    repeat (8) begin
      @(posedge ref_clk);
      #1;
      chk({read_data_c_oe, read_data_cn_oe}, 2'h0);
    end
  endtask
  task wrap_up;
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk({read_data_c_oe, read_data_cn_oe}, 2'h0);
    t_full;
    t_lanes;
    t_none;
    t_addr;
    t_stby;
    wrap_up;
  end
  // watchdog well past the expected run
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    wrap_up;
  end
endmodule
